/* File: verif/fmb_math_bench.sv */
// self-checking bench for fmb_math: a table of equations, then hold, enable, interrupt and reset cases
// assumes fmb_pkg, fmb_regs.svh and fmb_peer compiled first; ce and wstrb stay tied high
`timescale 1ns/1ps
`default_nettype none
`include "fmb_regs.svh"
module fmb_math_bench;
  import fmb_pkg::*;
  typedef struct packed {
    logic [31:0]      ops;
    logic [3:0][16:0] o;
    logic [15:0]      sel;
    logic [15:0]      res;
    logic             zd;
    logic             of;
  } fmb_row_s;
  logic               clk;
  logic               resetn;
  logic               ce;
  logic               en_in;
  logic               scan_tick;
  logic [15:0]        sel;
  fmb_ext_s           ext_value;
  logic signed [15:0] result_output;
  logic               zero_division_flag;
  logic               overflow_flag;
  logic               irq;
  logic [7:0]         s_axi_awaddr;
  logic               s_axi_awvalid;
  logic               s_axi_awready;
  logic [31:0]        s_axi_wdata;
  logic [3:0]         s_axi_wstrb;
  logic               s_axi_wvalid;
  logic               s_axi_wready;
  logic [1:0]         s_axi_bresp;
  logic               s_axi_bvalid;
  logic               s_axi_bready;
  logic [7:0]         s_axi_araddr;
  logic               s_axi_arvalid;
  logic               s_axi_arready;
  logic [31:0]        s_axi_rdata;
  logic [1:0]         s_axi_rresp;
  logic               s_axi_rvalid;
  logic               s_axi_rready;
  logic [31:0]        rd;
  logic [1:0]         rsp;
  int                 error_cnt = 0;
  int                 checks_done = 0;
  int                 cyc = 0;
  fmb_row_s           rows [13];

  fmb_math uut (.clk, .resetn, .ce, .en_in, .scan_tick, .ext_value, .result_output, .zero_division_flag,
    .overflow_flag, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fmb_peer peer (.sel, .ext_value);

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  // handshakes are sampled at the falling edge and acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ah;
    logic wh;
    logic bh;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ah;
    logic rh;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic load(input fmb_row_s r);
    axi_wr(`FMB_ADDR_OPS, r.ops);
    for (int k = 0; k < 4; k++) begin
      axi_wr(8'(`FMB_ADDR_OPND0 + 4 * k), {15'h0, r.o[k]});
    end
    sel <= r.sel;
  endtask : load

  // enable low for one edge, then high together with a scan pulse; result lands four edges on
  task automatic do_run();
    @(posedge clk);
    en_in <= 1'b0;
    @(posedge clk);
    en_in <= 1'b1;
    scan_tick <= 1'b1;
    @(posedge clk);
    scan_tick <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask : do_run

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the whole run needs about 560 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    {resetn, en_in, scan_tick, sel} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    rows[0] = '{32'h01b4, {17'h1, 17'h3, 17'h6, 17'hc}, 16'h0, 16'h000d, 1'b0, 1'b0};
    rows[1] = '{32'h0860, {17'h4, 17'h1, 17'h3, 17'h2}, 16'h0, 16'h0011, 1'b0, 1'b0};
    rows[2] = '{32'h0439, {17'h1, 17'h2, 17'h19, 17'h64}, 16'h0, 16'h0019, 1'b0, 1'b0};
    rows[3] = '{32'h0111, {17'h1, 17'h2, 17'h3, 17'ha}, 16'h0, 16'h0004, 1'b0, 1'b0};
    rows[4] = '{32'h0003, {17'h0, 17'h0, 17'h2, 17'h7}, 16'h0, 16'h0004, 1'b0, 1'b0};
    rows[5] = '{32'h0003, {17'h0, 17'h0, 17'h2, 17'hfff9}, 16'h0, 16'hfffc, 1'b0, 1'b0};
    rows[6] = '{32'h0023, {17'h0, 17'h3, 17'h3, 17'h1}, 16'h0, 16'h0001, 1'b0, 1'b0};
    rows[7] = '{32'h0003, {17'h0, 17'h0, 17'h0, 17'h5}, 16'h0, 16'h7fff, 1'b1, 1'b0};
    rows[8] = '{32'h0002, {17'h0, 17'h0, 17'h12c, 17'h12c}, 16'h0, 16'h7fff, 1'b0, 1'b1};
    rows[9] = '{32'h0002, {17'h0, 17'h0, 17'h12c, 17'hfed4}, 16'h0, 16'h8000, 1'b0, 1'b1};
    rows[10] = '{32'h0001, {17'h0, 17'h0, 17'h7fff, 17'h10000}, 16'h0002, 16'h0000, 1'b0, 1'b0};
    rows[11] = '{32'h0000, {17'h10000, 17'h0, 17'h0, 17'h0}, 16'h3000, 16'h8000, 1'b0, 1'b0};
    rows[12] = '{32'h0002, {17'h0, 17'h0, 17'h10000, 17'h5}, 16'h0010, 16'h01f4, 1'b0, 1'b0};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk("reset outputs", 32'h0, {13'h0, irq, zero_division_flag, overflow_flag, result_output});
    axi_rd(`FMB_ADDR_OPS);
    chk("ops reset", `FMB_RST_OPS, rd);
    axi_rd(8'h40);
    chk("unmapped read", 32'h2, {rd[29:0], rsp});
    axi_wr(8'h40, 32'h1);
    chk("unmapped write", 32'h2, {30'h0, rsp});
    $display("reset and bus test done");
    foreach (rows[i]) begin
      load(rows[i]);
      do_run();
      chk("result", {16'h0, rows[i].res}, {16'h0, result_output});
      chk("flags", {rows[i].zd, rows[i].of}, {zero_division_flag, overflow_flag});
      axi_rd(`FMB_ADDR_RESULT);
      chk("result reg", {13'h0, rows[i].of, rows[i].zd, rows[i].res}, rd);
      $display("row %0d done", i);
    end
    axi_wr(`FMB_ADDR_CTRL, 32'h1);
    load(rows[0]);
    do_run();
    @(posedge clk);
    en_in <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("held result", 32'h000d, {16'h0, result_output});
    axi_wr(`FMB_ADDR_OPND3, 32'h64);
    @(posedge clk);
    en_in <= 1'b1;
    repeat (2) @(posedge clk);
    scan_tick <= 1'b1;
    @(posedge clk);
    scan_tick <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("late tick result", 32'h000d, {16'h0, result_output});
    axi_wr(`FMB_ADDR_CTRL, 32'h0);
    @(negedge clk);
    chk("enabled result", 32'h000d, {16'h0, result_output});
    @(posedge clk);
    en_in <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("cleared result", 32'h0, {16'h0, result_output});
    $display("hold and enable test done");
    axi_wr(`FMB_ADDR_INT_STAT, 32'h7);
    axi_wr(`FMB_ADDR_INT_MASK, 32'h1);
    @(negedge clk);
    chk("irq idle", 32'h0, {31'h0, irq});
    load(rows[7]);
    do_run();
    chk("irq raised", 32'h1, {31'h0, irq});
    axi_rd(`FMB_ADDR_INT_STAT);
    chk("int status", 32'h3, rd);
    axi_wr(`FMB_ADDR_INT_STAT, 32'h3);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    axi_wr(`FMB_ADDR_INT_MASK, 32'h0);
    do_run();
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("interrupt test done");
    load(rows[0]);
    @(posedge clk);
    en_in <= 1'b0;
    @(posedge clk);
    en_in <= 1'b1;
    scan_tick <= 1'b1;
    @(posedge clk);
    scan_tick <= 1'b0;
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("second reset", 32'h0, {14'h0, zero_division_flag, overflow_flag, result_output});
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : fmb_math_bench
`default_nettype wire

/* File: verif/fmb_peer.sv */
// model of the other function blocks whose actual values feed the external operands
// assumes sel holds four 4-bit block numbers, operand 0 in the low nibble
`timescale 1ns/1ps
`default_nettype none
module fmb_peer (
  input  wire logic [15:0]        sel,
  output var  fmb_pkg::fmb_ext_s  ext_value
);
  import fmb_pkg::*;
  // actual values reach past the 16-bit operand range on purpose, so limiting can be seen
  function automatic logic signed [31:0] blk_val(input logic [3:0] n);
    case (n)
      4'h1:    blk_val = 32'sh0000_0064;
      4'h2:    blk_val = 32'sh0000_9c40;
      4'h3:    blk_val = 32'shffff_3cb0;
      default: blk_val = 32'sh0000_0000;
    endcase
  endfunction : blk_val
  always_comb begin
    ext_value.v0 = blk_val(sel[3:0]);
    ext_value.v1 = blk_val(sel[7:4]);
    ext_value.v2 = blk_val(sel[11:8]);
    ext_value.v3 = blk_val(sel[15:12]);
  end
endmodule : fmb_peer
`default_nettype wire

/* File: verilog/fmb_math.sv */
// four operand math block: axi4-lite register slave, sequential equation evaluator, interrupt
// assumes ext_value, en_in and scan_tick come from logic on clk; awaddr/araddr are byte addresses
`timescale 1ns/1ps
`default_nettype none
`include "fmb_regs.svh"

// Contract
// - evaluation starts after enable goes from low to high; here only if scan_tick is high in the first cycle enable is high
// - always four operands and three operators; neutral fill is software's job
// - each operator adds, subtracts, multiplies or divides its neighbours
// - round-marked operation first, then square-marked, then unmarked
// - result rounded to nearest integer before output
// - negative overflow forces output to -32768
// - hold setting 0: output zero while enable is low
// - hold setting 1: output keeps last value while enable is low
// - external operand outside range is limited to -32768 or 32767
// - separate zero division and overflow flags per execution
// - both flags rewritten at the end of each execution, one or zero
module fmb_math (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire logic                en_in,
  input  wire logic                scan_tick,
  input  wire fmb_pkg::fmb_ext_s   ext_value,
  output logic signed [15:0]       result_output,
  output logic                     zero_division_flag,
  output logic                     overflow_flag,
  output logic                     irq,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import fmb_pkg::*;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

  function automatic logic signed [15:0] clamp16(input logic signed [63:0] x);
    if (x > 64'sd32767) begin
      return 16'sh7fff;
    end else if (x < -64'sd32768) begin
      return 16'sh8000;
    end
    return x[15:0];
  endfunction : clamp16

  // index of the next operation among the n live ones
  function automatic logic [1:0] pick_op(input fmb_opcfg_s [2:0] c, input logic [1:0] n);
    logic [1:0] sq;
    logic       fr;
    logic       fs;
    sq = 2'd0;
    fr = 1'b0;
    fs = 1'b0;
    pick_op = 2'd0;
    for (int i = 0; i < 3; i++) begin
      if (2'(i) < n && !fr && c[i].mark == FMB_MK_ROUND) begin
        pick_op = 2'(i);
        fr = 1'b1;
      end
      if (2'(i) < n && !fs && c[i].mark == FMB_MK_SQUARE) begin
        sq = 2'(i);
        fs = 1'b1;
      end
    end
    if (!fr && fs) begin
      pick_op = sq;
    end
  endfunction : pick_op

  // ---------------- register file and axi4-lite slave ----------------
  logic              hold_ff;
  fmb_opcfg_s [2:0]  ops_ff;
  logic [16:0]       opnd_ff [4];
  logic [2:0]        int_stat_ff;
  logic [2:0]        int_mask_ff;
  logic              aw_ok_ff;
  logic              w_ok_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              wr_go;
  logic [31:0]       wm;
  logic              wr_hit;
  logic [2:0]        int_evt;
  logic [31:0]       rd_word;
  logic              rd_hit;

  assign s_axi_awready = ce && !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_ok_ff && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_go         = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign wm            = lane_mask(wstrb_ff) & wdata_ff;
  assign wr_hit        = awaddr_ff <= `FMB_ADDR_INT_MASK && awaddr_ff[1:0] == 2'b00;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      awaddr_ff <= 8'h0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ok_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_ok_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // partial writes merge byte lanes into the stored value
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_ff     <= 1'b0;
      ops_ff      <= 12'(`FMB_RST_OPS);
      int_mask_ff <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        opnd_ff[i] <= 17'h0;
      end
    end else if (ce && wr_go) begin
      if (awaddr_ff == `FMB_ADDR_CTRL && wstrb_ff[0]) begin
        hold_ff <= wdata_ff[`FMB_CTRL_HOLD];
      end
      if (awaddr_ff == `FMB_ADDR_OPS) begin
        ops_ff <= 12'((ops_ff & ~lane_mask(wstrb_ff)) | wm);
      end
      if (awaddr_ff == `FMB_ADDR_INT_MASK && wstrb_ff[0]) begin
        int_mask_ff <= wdata_ff[2:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (awaddr_ff == 8'(`FMB_ADDR_OPND0 + 4 * i)) begin
          opnd_ff[i] <= 17'(({15'h0, opnd_ff[i]} & ~lane_mask(wstrb_ff)) | wm);
        end
      end
    end
  end

  // ---------------- evaluator ----------------
  fmb_state_e         state_ff;
  logic [1:0]         nops_ff;
  fmb_fix_t           val_ff [4];
  fmb_opcfg_s [2:0]   cfg_ff;
  logic               zd_ff;
  logic               en_prev_ff;
  logic               start;
  logic [1:0]         k;
  fmb_fix_t           a;
  fmb_fix_t           b;
  fmb_fix_t           step_res;
  logic               step_zd;
  logic signed [127:0] prod;
  logic signed [79:0]  quot;
  logic signed [47:0]  rnd;
  logic               fin;
  logic               fin_ovf;
  logic signed [15:0] fin_val;
  logic signed [15:0] opnd_v [4];

  // only a fresh rising edge of enable, seen on a scan tick, launches a run
  assign start = ce && scan_tick && en_in && !en_prev_ff && state_ff == FMB_IDLE;
  assign fin   = ce && state_ff == FMB_FIN;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_opnd
      logic signed [31:0] ext_w;
      assign ext_w = ext_value[g*32 +: 32];
      // external source is saturated before it enters the equation
      assign opnd_v[g] = opnd_ff[g][`FMB_OPND_EXT] ? clamp16(64'(ext_w)) : opnd_ff[g][15:0];
    end
  endgenerate

  always_comb begin
    k        = pick_op(cfg_ff, nops_ff);
    a        = val_ff[k];
    b        = val_ff[k + 2'd1];
    step_zd  = 1'b0;
    prod     = 128'(a) * 128'(b);
    quot     = 80'sh0;
    step_res = 64'sh0;
    case (cfg_ff[k].op)
      FMB_ADD: step_res = a + b;
      FMB_SUB: step_res = a - b;
      FMB_MUL: step_res = prod[64 + `FMB_FRAC - 1:`FMB_FRAC];
      FMB_DIV: begin
        if (b == 64'sh0) begin
          step_zd = 1'b1;
        end else begin
          // both sides signed, else a negative dividend divides as a huge unsigned value
          quot     = $signed({a, 16'h0}) / 80'(b);
          step_res = quot[63:0];
        end
      end
      default: step_res = a;
    endcase
  end

  // round half away from zero, then saturate
  always_comb begin
    if (val_ff[0] >= 64'sh0) begin
      rnd = 48'((val_ff[0] + 64'sh8000) >>> `FMB_FRAC);
    end else begin
      rnd = -48'((-val_ff[0] + 64'sh8000) >>> `FMB_FRAC);
    end
    fin_ovf = rnd > 48'sd32767 || rnd < -48'sd32768;
    fin_val = zd_ff ? 16'sh7fff : clamp16(64'(rnd));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_prev_ff <= 1'b0;
    end else if (ce) begin
      en_prev_ff <= en_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= FMB_IDLE;
      nops_ff  <= 2'd0;
      zd_ff    <= 1'b0;
      cfg_ff   <= 12'h0;
      for (int i = 0; i < 4; i++) begin
        val_ff[i] <= 64'sh0;
      end
    end else if (ce) begin
      case (state_ff)
        FMB_IDLE: begin
          if (start) begin
            state_ff <= FMB_CALC;
            nops_ff  <= 2'd3;
            zd_ff    <= 1'b0;
            cfg_ff   <= ops_ff;
            for (int i = 0; i < 4; i++) begin
              val_ff[i] <= 64'(opnd_v[i]) <<< `FMB_FRAC;
            end
          end
        end
        FMB_CALC: begin
          // merge the chosen pair, close the gap to its right
          val_ff[k] <= step_res;
          for (int i = 1; i < 3; i++) begin
            if (2'(i) > k) begin
              val_ff[i]  <= val_ff[i + 1];
              cfg_ff[i - 1] <= cfg_ff[i];
            end
          end
          zd_ff   <= zd_ff | step_zd;
          nops_ff <= nops_ff - 2'd1;
          if (nops_ff == 2'd1) begin
            state_ff <= FMB_FIN;
          end
        end
        FMB_FIN: state_ff <= FMB_IDLE;
        default: state_ff <= FMB_IDLE;
      endcase
    end
  end

  // a run that ends after enable fell does not overwrite a cleared output
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_output <= 16'sh0;
    end else if (ce) begin
      if (!en_in && !hold_ff) begin
        result_output <= 16'sh0;
      end else if (fin && en_in) begin
        result_output <= fin_val;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      zero_division_flag <= 1'b0;
      overflow_flag      <= 1'b0;
    end else if (fin) begin
      zero_division_flag <= zd_ff;
      overflow_flag      <= !zd_ff && fin_ovf;
    end
  end

  // ---------------- interrupt: sticky, write one to clear, set wins ----------------
  assign int_evt = {fin && !zd_ff && fin_ovf, fin && zd_ff, fin};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_stat_ff <= 3'h0;
    end else if (ce) begin
      int_stat_ff <= (int_stat_ff & ~((wr_go && awaddr_ff == `FMB_ADDR_INT_STAT) ? wm[2:0] : 3'h0)) | int_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(int_stat_ff & int_mask_ff);
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    case (s_axi_araddr)
      `FMB_ADDR_CTRL:     rd_word = {31'h0, hold_ff};
      `FMB_ADDR_OPS:      rd_word = {20'h0, ops_ff};
      `FMB_ADDR_OPND0:    rd_word = {15'h0, opnd_ff[0]};
      `FMB_ADDR_OPND1:    rd_word = {15'h0, opnd_ff[1]};
      `FMB_ADDR_OPND2:    rd_word = {15'h0, opnd_ff[2]};
      `FMB_ADDR_OPND3:    rd_word = {15'h0, opnd_ff[3]};
      `FMB_ADDR_RESULT:   rd_word = {13'h0, state_ff != FMB_IDLE, overflow_flag, zero_division_flag, result_output};
      `FMB_ADDR_INT_STAT: rd_word = {29'h0, int_stat_ff};
      `FMB_ADDR_INT_MASK: rd_word = {29'h0, int_mask_ff};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- assertions ----------------
  property p_start_edge;
    @(posedge clk) disable iff (!resetn) start |-> !$past(en_in);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("run started without enable edge");

  property p_latency;
    @(posedge clk) disable iff (!resetn) start ##1 ce [*3] |-> ##1 state_ff == FMB_FIN;
  endproperty
  a_latency: assert property (p_latency) else $error("evaluation did not finish in four cycles");

  property p_zd_sat;
    @(posedge clk) disable iff (!resetn) fin && en_in && zd_ff |=> result_output == 16'sh7fff && zero_division_flag;
  endproperty
  a_zd_sat: assert property (p_zd_sat) else $error("zero division did not saturate high");

  property p_neg_sat;
    @(posedge clk) disable iff (!resetn) fin && en_in && !zd_ff && rnd < -48'sd32768 |=> result_output == 16'sh8000 && overflow_flag;
  endproperty
  a_neg_sat: assert property (p_neg_sat) else $error("negative overflow not at most negative value");

  property p_clear;
    @(posedge clk) disable iff (!resetn) ce && !en_in && !hold_ff |=> result_output == 16'sh0;
  endproperty
  a_clear: assert property (p_clear) else $error("output not zero while disabled");

  property p_hold;
    @(posedge clk) disable iff (!resetn) ce && !en_in && hold_ff && !wr_go |=> $stable(result_output);
  endproperty
  a_hold: assert property (p_hold) else $error("held output changed while disabled");

  property p_flags_clean;
    @(posedge clk) disable iff (!resetn) fin && !zd_ff && !fin_ovf |=> !zero_division_flag && !overflow_flag;
  endproperty
  a_flags_clean: assert property (p_flags_clean) else $error("error flags not cleared after clean run");

  property p_round;
    @(posedge clk) disable iff (!resetn) fin && en_in && !zd_ff && !fin_ovf |=> result_output == $past(rnd[15:0]);
  endproperty
  a_round: assert property (p_round) else $error("output is not the rounded result");

  c_zero_div: cover property (@(posedge clk) disable iff (!resetn) fin && zd_ff);
  c_overflow: cover property (@(posedge clk) disable iff (!resetn) fin && fin_ovf && !zd_ff);
  c_clean:    cover property (@(posedge clk) disable iff (!resetn) fin && en_in && !zd_ff && !fin_ovf);
  c_hold:     cover property (@(posedge clk) disable iff (!resetn) hold_ff && $fell(en_in));
endmodule : fmb_math
`default_nettype wire

/* File: verilog/fmb_pkg.sv */
// types shared by the four operand math block
// assumes fmb_regs.svh on the include path
`default_nettype none
package fmb_pkg;
  typedef enum logic [1:0] {FMB_ADD, FMB_SUB, FMB_MUL, FMB_DIV} fmb_op_e;
  typedef enum logic [1:0] {FMB_MK_NONE, FMB_MK_SQUARE, FMB_MK_ROUND} fmb_mark_e;
  typedef struct packed {
    fmb_mark_e mark;
    fmb_op_e   op;
  } fmb_opcfg_s;
  typedef logic signed [63:0] fmb_fix_t;
  typedef struct packed {
    logic signed [31:0] v3;
    logic signed [31:0] v2;
    logic signed [31:0] v1;
    logic signed [31:0] v0;
  } fmb_ext_s;
  typedef enum logic [1:0] {FMB_IDLE, FMB_CALC, FMB_FIN} fmb_state_e;
endpackage : fmb_pkg
`default_nettype wire

/* File: verilog/fmb_regs.svh */
// register map, field positions and fixed-point constants of the four operand math block
// assumes inclusion by bare name from the bench and the block
`ifndef FMB_REGS_SVH
`define FMB_REGS_SVH
`define FMB_ADDR_CTRL     8'h00
`define FMB_ADDR_OPS      8'h04
`define FMB_ADDR_OPND0    8'h08
`define FMB_ADDR_OPND1    8'h0c
`define FMB_ADDR_OPND2    8'h10
`define FMB_ADDR_OPND3    8'h14
`define FMB_ADDR_RESULT   8'h18
`define FMB_ADDR_INT_STAT 8'h1c
`define FMB_ADDR_INT_MASK 8'h20
`define FMB_CTRL_HOLD     0
`define FMB_OPND_EXT      16
`define FMB_RES_ZD        16
`define FMB_RES_OF        17
`define FMB_RES_BUSY      18
`define FMB_INT_DONE      0
`define FMB_INT_ZD        1
`define FMB_INT_OF        2
`define FMB_RST_OPS       32'h0000_0000
`define FMB_FRAC          16
`define FMB_MAX_POS       32767
`define FMB_MAX_NEG       -32768
`endif
